// ===== nvm_access_pkg.sv
// Constants, register map and timing of the nonvolatile data array access block.
// Assumes a core that reaches its special registers by sector and byte offset.
package nvm_access_pkg;

  // ==========================================================================
  // Register map
  localparam logic       SECTOR_DIRECT   = 1'b0;
  localparam logic       SECTOR_INDIRECT = 1'b1;
  localparam logic [7:0] OFS_ADDRESS     = 8'h1A;  // sector 0, placement of this core
  localparam logic [7:0] OFS_DATA        = 8'h1B;  // sector 0, placement of this core
  localparam logic [7:0] OFS_CONTROL     = 8'h40;  // sector 1

  // ==========================================================================
  // Field positions
  localparam int ADDR_W        = 6;
  localparam int DEPTH         = 64;
  localparam int BIT_PROG_PERM = 3;
  localparam int BIT_WR_START  = 2;
  localparam int BIT_FETCH_PERM = 1;
  localparam int BIT_RD_START  = 0;

  // ==========================================================================
  // Reset values
  localparam logic [5:0] RST_ADDRESS = 6'h00;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [3:0] RST_CONTROL = 4'h0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int WRITE_TIME_NS  = 2000;
  localparam int READ_TIME_NS   = 100;
  localparam int WRITE_CYCLES   = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES    = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} nvm_state_t;

endpackage : nvm_access_pkg

// ===== nvm_access.sv
// Nonvolatile data array with address, data and control registers.
// Assumes the core presents one register access per cycle, already resolved
// to sector and offset (indirect pointer path resolved by the core).
// Register accesses and array cycles all run on the one system clock.
// Array content is not cleared by reset and starts unknown in simulation.
`timescale 1ns/1ps
module nvm_access
  import nvm_access_pkg::*;
#(
  parameter int WR_CYCLES = WRITE_CYCLES,
  parameter int RD_CYCLES = READ_CYCLES
)(
  input  wire logic       i_clk_sys,  // System clock, 20 MHz
  input  wire logic       i_rst,      // Synchronous reset, active high
  input  wire logic       i_sector,   // Register sector of the access
  input  wire logic [7:0] i_offset,   // Register offset within sector
  input  wire logic       i_indirect, // Access arrives via indirect port
  input  wire logic       i_we,       // Register write strobe
  input  wire logic       i_re,       // Register read strobe
  input  wire logic [7:0] i_wdata,    // Write data
  output logic      [7:0] o_rdata,    // Read data, valid cycle after i_re
  output logic            o_busy      // Array cycle in progress
);

  typedef struct packed {
    // Sequencer
    nvm_state_t      st;
    // Software-visible registers
    logic [5:0]      addr;
    logic [7:0]      data;
    // Control register bits
    logic            prog_perm;
    logic            wr_start;
    logic            fetch_perm;
    logic            rd_start;
    // Frozen operation and its counter
    logic [5:0]      op_addr;
    logic [7:0]      op_data;
    logic [CNT_W-1:0] cnt;
    // Read port
    logic [7:0]      rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic [7:0] mem_r [DEPTH];
  logic       sel_addr;
  logic       sel_data;
  logic       sel_ctl;
  logic       mem_we;
  logic [7:0] ctl_view;
  logic       ctl_wr;
  logic       can_go;
  logic       wr_go;
  logic       rd_go;
  logic       op_done;
  logic [7:0] rd_mux;

  // ==========================================================================
  // Decode
  // Control answers only on the pointer path; a direct access to the
  // same sector and offset is unmapped and reads zero
  assign sel_addr = (i_sector == SECTOR_DIRECT) && (i_offset == OFS_ADDRESS);
  assign sel_data = (i_sector == SECTOR_DIRECT) && (i_offset == OFS_DATA);
  assign sel_ctl  = (i_sector == SECTOR_INDIRECT) && i_indirect
                    && (i_offset == OFS_CONTROL);

  // Upper control bits are unimplemented and read zero
  assign ctl_view = {4'h0, state_r.prog_perm, state_r.wr_start,
                     state_r.fetch_perm, state_r.rd_start};

  // ==========================================================================
  // Read mux
  always_comb
  begin
    rd_mux = 8'h00;
    if (sel_addr)
    begin
      rd_mux = {2'b00, state_r.addr};
    end
    else if (sel_data)
    begin
      rd_mux = state_r.data;
    end
    else if (sel_ctl)
    begin
      rd_mux = ctl_view;
    end
  end

  // ==========================================================================
  // Start requests
  // Permits are judged on their stored value, so a permit and its start in
  // one write launch a cycle only if that permit was already stored; a start while busy is dropped
  assign ctl_wr  = i_we && sel_ctl;
  assign can_go  = (state_r.st == ST_IDLE);
  assign op_done = (state_r.cnt == '0);
  assign wr_go   = ctl_wr && can_go && i_wdata[BIT_WR_START]
                   && state_r.prog_perm;
  // Write wins should both starts arrive together
  assign rd_go   = ctl_wr && can_go && !wr_go && i_wdata[BIT_RD_START]
                   && state_r.fetch_perm;

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_nxt = state_r;
    mem_we    = 1'b0;

    // Read data is captured only on a read strobe and then stands
    if (i_re)
    begin
      state_nxt.rdata = rd_mux;
    end

    // Register writes
    if (i_we && sel_addr)
    begin
      state_nxt.addr = i_wdata[ADDR_W-1:0];
    end
    if (i_we && sel_data)
    begin
      state_nxt.data = i_wdata;
    end
    if (ctl_wr)
    begin
      // Permits follow every control write, busy or not
      state_nxt.prog_perm  = i_wdata[BIT_PROG_PERM];
      state_nxt.fetch_perm = i_wdata[BIT_FETCH_PERM];
    end

    // Launch; address and data are frozen for the whole write
    if (wr_go)
    begin
      state_nxt.wr_start = 1'b1;
      state_nxt.st       = ST_WRITE;
      state_nxt.op_addr  = state_r.addr;
      state_nxt.op_data  = state_r.data;
      state_nxt.cnt      = CNT_W'(WR_CYCLES - 1);
    end
    else if (rd_go)
    begin
      state_nxt.rd_start = 1'b1;
      state_nxt.st       = ST_READ;
      state_nxt.op_addr  = state_r.addr;
      state_nxt.cnt      = CNT_W'(RD_CYCLES - 1);
    end

    // Start bits are cleared only here and by reset, never by software
    case (state_r.st)
      ST_IDLE:
      begin
        // Nothing counts while idle
      end
      ST_WRITE:
      begin
        if (op_done)
        begin
          // Byte lands on the last count, as the start bit clears
          mem_we             = 1'b1;
          state_nxt.wr_start = 1'b0;
          state_nxt.st       = ST_IDLE;
        end
        else
          state_nxt.cnt = state_r.cnt - 1'b1;
      end
      ST_READ:
      begin
        if (op_done)
        begin
          // Array byte wins over a same-cycle software data write
          state_nxt.data     = mem_r[state_r.op_addr];
          state_nxt.rd_start = 1'b0;
          state_nxt.st       = ST_IDLE;
        end
        else
          state_nxt.cnt = state_r.cnt - 1'b1;
      end
      default: state_nxt.st = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      // Synchronous reset clears every field; the array is left alone
      state_r.st         <= ST_IDLE;
      state_r.addr       <= RST_ADDRESS;
      state_r.data       <= RST_DATA;
      {state_r.prog_perm, state_r.wr_start,
       state_r.fetch_perm, state_r.rd_start} <= RST_CONTROL;
      state_r.op_addr    <= '0;
      state_r.op_data    <= '0;
      state_r.cnt        <= '0;
      // Read data shows zero until the first read
      state_r.rdata      <= '0;
    end
    else
      state_r <= state_nxt;
  end

  // ==========================================================================
  // Array storage
  // Array content is kept over reset, as nonvolatile storage would be
  always_ff @(posedge i_clk_sys)
  begin
    if (mem_we)
      mem_r[state_r.op_addr] <= state_r.op_data;
  end

  // ==========================================================================
  // Outputs
  // Busy is decoded straight from the state register, no extra stage
  assign o_rdata = state_r.rdata;
  assign o_busy  = (state_r.st != ST_IDLE);

endmodule : nvm_access

// ===== core_model.sv
// Processor core model issuing one register access at a time.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/1ps
module core_model (
  input  wire logic       i_clk_sys,  // System clock
  input  wire logic [7:0] i_rdata,    // Read data from block
  output logic            o_sector,   // Sector
  output logic      [7:0] o_offset,   // Offset
  output logic            o_indirect, // Pointer path
  output logic            o_we,       // Write strobe
  output logic            o_re,       // Read strobe
  output logic      [7:0] o_wdata     // Write data
);
  // ====
  // Access task
  initial {o_sector, o_offset, o_indirect, o_we, o_re, o_wdata} = '0;
  task automatic acc(input logic s, input logic ind, input logic [7:0] o,
                     input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk_sys);
    {o_sector, o_indirect, o_offset, o_wdata} = {s, ind, o, d};
    {o_we, o_re} = {w, !w};
    @(negedge i_clk_sys);
    q = i_rdata;
    {o_we, o_re} = 2'b00;
    // Idle data inverted so a stale byte cannot pass
    o_wdata = ~d;
  endtask : acc
endmodule : core_model

// ===== nvm_access_checker.sv
// Assertions on the register port of the array access block.
// Assumes the package offsets and one access per cycle.
`timescale 1ns/1ps
module nvm_access_checker
  import nvm_access_pkg::*;
#(
  parameter int WR_CYCLES = 4,
  parameter int RD_CYCLES = 2
)(
  input wire logic       i_clk_sys,  // System clock
  input wire logic       i_rst,      // Synchronous reset, active high
  input wire logic       i_sector,   // Register sector
  input wire logic [7:0] i_offset,   // Register offset
  input wire logic       i_indirect, // Pointer path flag
  input wire logic       i_we,       // Write strobe
  input wire logic       i_re,       // Read strobe
  input wire logic [7:0] i_wdata,    // Write data
  input wire logic [7:0] o_rdata,    // Read data from block
  input wire logic       o_busy      // Array cycle running
);
  // ====
  // Helper state
  logic [1:0]  perm_r;
  logic [15:0] cnt_r;
  wire ctl_w = i_we && i_sector && i_indirect && i_offset == OFS_CONTROL;
  always_ff @(posedge i_clk_sys)
  begin
    perm_r <= i_rst ? 2'b00 : ctl_w ? {i_wdata[BIT_PROG_PERM], i_wdata[BIT_FETCH_PERM]} : perm_r;
    cnt_r  <= (i_rst || !o_busy) ? 16'h0 : cnt_r + 16'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  rst_clear_a: assert property (
    $past(i_rst) |-> o_rdata == 8'h00 && !o_busy)
    else $error("state not cleared by reset");
  unmapped_zero_a: assert property (
    i_re && i_sector && !i_indirect |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  addr_top_a: assert property (
    i_re && !i_sector && i_offset == OFS_ADDRESS |=> o_rdata[7:6] == 2'b00)
    else $error("address top bits not zero");
  ctl_top_a: assert property (
    i_re && ctl_w == 1'b0 && i_sector && i_indirect && i_offset == OFS_CONTROL
      |=> o_rdata[7:4] == 4'h0)
    else $error("control top bits not zero");
  rdata_hold_a: assert property (
    !i_re |=> $stable(o_rdata))
    else $error("read data moved without read");
  no_start_a: assert property (
    ctl_w && !o_busy && perm_r == 2'b00 |=> !o_busy)
    else $error("cycle started without permit");
  wr_start_a: assert property (
    ctl_w && !o_busy && perm_r[1] && i_wdata[BIT_WR_START] |=> o_busy)
    else $error("permitted write did not start");
  busy_bound_a: assert property (
    o_busy |-> cnt_r < WR_CYCLES)
    else $error("array cycle too long");
  rd_done_a: assert property (
    ctl_w && !o_busy && perm_r[0] && i_wdata[BIT_RD_START]
      && !(perm_r[1] && i_wdata[BIT_WR_START]) |=> o_busy ##RD_CYCLES !o_busy)
    else $error("read cycle length wrong");
endmodule : nvm_access_checker
bind nvm_access nvm_access_checker #(.WR_CYCLES(WR_CYCLES), .RD_CYCLES(RD_CYCLES)) chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sector(i_sector), .i_offset(i_offset),
  .i_indirect(i_indirect), .i_we(i_we), .i_re(i_re), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_busy(o_busy));

// ===== tb_top.sv
// Register-level testbench of the array access block.
// Assumes short array cycles set through parameters.
`timescale 1ns/1ps
module tb_top
  import nvm_access_pkg::*;
;
  logic       i_clk_sys, i_rst, sec, ind, we, re, busy;
  logic [7:0] ofs, wd, rd, q;
  int         miscompares = 0;
  int         cmp_count = 0;
  core_model p (.i_clk_sys(i_clk_sys), .i_rdata(rd), .o_sector(sec), .o_offset(ofs),
    .o_indirect(ind), .o_we(we), .o_re(re), .o_wdata(wd));
  nvm_access #(.WR_CYCLES(4), .RD_CYCLES(2)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_sector(sec), .i_offset(ofs), .i_indirect(ind), .i_we(we), .i_re(re), .i_wdata(wd),
    .o_rdata(rd), .o_busy(busy));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // ====
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    p.acc(o == OFS_CONTROL, o == OFS_CONTROL, o, 1'b1, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] o, input logic [7:0] exp);
    p.acc(o == OFS_CONTROL, o == OFS_CONTROL, o, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask : rc
  task automatic idle();
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(negedge i_clk_sys);
    chk({7'h00, busy}, 8'h00);
  endtask : idle
  task automatic results();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    #150000;
    miscompares++;
    results();
  end
  initial
  begin
    i_rst = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    i_rst = 1'b0;
    rc(OFS_ADDRESS, 8'h00);
    rc(OFS_DATA, 8'h00);
    wr(OFS_ADDRESS, 8'hFF);
    rc(OFS_ADDRESS, 8'h3F);
    p.acc(1'b1, 1'b0, OFS_CONTROL, 1'b1, 8'h0A, q);
    p.acc(1'b1, 1'b0, OFS_CONTROL, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    rc(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'h04);
    chk({7'h00, busy}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_ADDRESS, i ? 8'h3F : 8'h00);
      wr(OFS_DATA, i ? 8'hC3 : 8'h5A);
      wr(OFS_CONTROL, 8'h08);
      wr(OFS_CONTROL, 8'h0C);
      chk({7'h00, busy}, 8'h01);
      wr(OFS_ADDRESS, 8'h15);
      idle();
      rc(OFS_CONTROL, 8'h08);
    end
    wr(OFS_CONTROL, 8'h01);
    chk({7'h00, busy}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_ADDRESS, i ? 8'h3F : 8'h00);
      wr(OFS_CONTROL, 8'h02);
      wr(OFS_CONTROL, 8'h03);
      idle();
      rc(OFS_CONTROL, 8'h02);
      rc(OFS_DATA, i ? 8'hC3 : 8'h5A);
    end
    results();
  end
endmodule : tb_top
